//--- exposure_and_readout_direction_ctrl.v
// Frame timing, rolling shutter and readout direction control for the image sensor.
//
// Summary of operation
// R1: Direction bit 0 selects vertical row order.
// R2: Direction bit 1 selects horizontal column order.
// R3: First frame after direction change is invalid.
// R4: Integration is frame minus sweep plus one lines.
// R5: Frame length in lines, from sync or register.
// R6: Slave mode counts sync lines per frame.
// R7: Master mode uses 18-bit lines-per-frame register.
// R8: Shutter sweep is 18 bits, reset zero.
// R9: Controller keeps sweep within one to length minus two; the block applies any written sweep unclamped.
// R10: New integration applies from next frame only.
// R11: Rolling shutter resets and reads each line.
// R12: Slave source lengthens frames by spacing sync pulses.
// R13: Extra master lines go to rear blanking.
// R14: Controller keeps frame length near one second; the block uses the register or measured length as given.
// R15: Multi-byte values captured whole at frame boundary.
`timescale 1ns/1ps
`default_nettype none
`include "frame_ctrl_defines.vh"

module exposure_and_readout_direction_ctrl #(
	parameter LINE_CYCLES = 16,
	parameter ACTIVE_LINES = 1097
) (
	// Clock and reset.
	input wire clk_in,
	input wire rst_in,
	// Operating mode strap, high selects master mode.
	input wire master_mode_in,
	// External sync from the timing generator, active low, slave mode only.
	input wire vertical_sync_pin_n_in,
	input wire horizontal_sync_pin_n_in,
	// Register port of the serial control interface.
	input wire [15:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	// Frame timing and readout control.
	output reg frame_start_out,
	output reg line_start_out,
	output reg line_active_out,
	output reg [`VALUE_W-1:0] read_row_out,
	output reg [`VALUE_W-1:0] shutter_row_out,
	output reg [`VALUE_W-1:0] integration_lines_out,
	output reg [`VALUE_W-1:0] frame_lines_out,
	output reg vertical_flip_out,
	output reg horizontal_flip_out,
	output reg frame_invalid_out
);

	// Software-written values and their per-frame shadows.
	reg [1:0] dir_r;
	reg [`VALUE_W-1:0] lpf_r;
	reg [`VALUE_W-1:0] shs_r;
	reg [`VALUE_W-1:0] lpf_act_r;
	reg [`VALUE_W-1:0] shs_act_r;
	reg master_r;
	reg strap_taken_r;
	// Line timing state.
	reg [15:0] cyc_r;
	reg [`VALUE_W-1:0] line_r;
	reg vs_d_r;
	reg hs_d_r;
	reg [`VALUE_W-1:0] line_nxt;
	reg fs_nxt;
	reg ls_nxt;
	reg [`VALUE_W-1:0] sweep_p1;
	reg [`VALUE_W-1:0] shut_nxt;
	reg measured_r;
	wire vs_fall;
	wire hs_fall;
	wire vflip_nxt;
	wire [31:0] act_last_w;

	// Last active row, kept wide here and cut on purpose where it meets a row address.
	assign act_last_w = ACTIVE_LINES - 1;
	// Direction the coming line is read in; a frame start already uses the new setting.
	assign vflip_nxt = fs_nxt ? dir_r[`VFLIP_BIT] : vertical_flip_out; // see R1

	assign vs_fall = vs_d_r & ~vertical_sync_pin_n_in;
	assign hs_fall = hs_d_r & ~horizontal_sync_pin_n_in;

	// Register writes land in the staging copies; nothing downstream sees them mid-frame.
	always @(posedge clk_in) begin
		if (rst_in) begin
			dir_r <= `DIR_RESET;
			lpf_r <= `LPF_RESET;
			shs_r <= `SHS_RESET;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`ADDR_READOUT_DIRECTION: dir_r <= reg_wdata_in[1:0]; // see R1 see R2
				`ADDR_LPF_0: lpf_r[7:0] <= reg_wdata_in; // see R7
				`ADDR_LPF_1: lpf_r[15:8] <= reg_wdata_in;
				`ADDR_LPF_2: lpf_r[17:16] <= reg_wdata_in[1:0];
				`ADDR_SHS_0: shs_r[7:0] <= reg_wdata_in; // see R8
				`ADDR_SHS_1: shs_r[15:8] <= reg_wdata_in;
				`ADDR_SHS_2: shs_r[17:16] <= reg_wdata_in[1:0];
				default: dir_r <= dir_r;
			endcase
		end
	end

	// Read data is registered; unmapped addresses and unused upper bits read as zero.
	always @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`ADDR_READOUT_DIRECTION: reg_rdata_out <= {6'h00, dir_r};
				`ADDR_LPF_0: reg_rdata_out <= lpf_r[7:0];
				`ADDR_LPF_1: reg_rdata_out <= lpf_r[15:8];
				`ADDR_LPF_2: reg_rdata_out <= {6'h00, lpf_r[17:16]};
				`ADDR_SHS_0: reg_rdata_out <= shs_r[7:0];
				`ADDR_SHS_1: reg_rdata_out <= shs_r[15:8];
				`ADDR_SHS_2: reg_rdata_out <= {6'h00, shs_r[17:16]};
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// The mode strap is caught once after reset release and held; it must not change later.
	always @(posedge clk_in) begin
		if (rst_in) begin
			master_r <= 1'b0;
			strap_taken_r <= 1'b0;
		end else if (!strap_taken_r) begin
			master_r <= master_mode_in;
			strap_taken_r <= 1'b1;
		end
	end

	// Next line and frame boundary, from the internal timer or from the external sync.
	always @* begin
		line_nxt = line_r;
		fs_nxt = 1'b0;
		ls_nxt = 1'b0;
		if (!strap_taken_r) begin
			line_nxt = line_r;
		end else if (master_r) begin
			if (cyc_r == LINE_CYCLES - 1) begin
				ls_nxt = 1'b1;
				if (line_r >= lpf_act_r - 18'h00001) begin // see R5 see R7
					line_nxt = {`VALUE_W{1'b0}};
					fs_nxt = 1'b1;
				end else begin
					line_nxt = line_r + 18'h00001;
				end
			end
		end else if (vs_fall) begin
			// A vertical sync edge both ends the frame and starts line zero.
			line_nxt = {`VALUE_W{1'b0}}; // see R6 see R12
			fs_nxt = 1'b1;
			ls_nxt = 1'b1;
		end else if (hs_fall) begin
			line_nxt = line_r + 18'h00001; // see R6
			ls_nxt = 1'b1;
		end
	end

	// Line timer, sync edge history and line counter.
	always @(posedge clk_in) begin
		if (rst_in) begin
			cyc_r <= 16'h0000;
			line_r <= {`VALUE_W{1'b0}};
			vs_d_r <= 1'b1;
			hs_d_r <= 1'b1;
		end else begin
			vs_d_r <= vertical_sync_pin_n_in;
			hs_d_r <= horizontal_sync_pin_n_in;
			line_r <= line_nxt;
			if (!master_r || cyc_r == LINE_CYCLES - 1) begin
				cyc_r <= 16'h0000;
			end else begin
				cyc_r <= cyc_r + 16'h0001;
			end
		end
	end

	// At each frame boundary the whole staged values are taken, so a frame never mixes
	// bytes of an old and a new setting.  In slave mode the frame length is the line
	// count just measured, since the external source sets it.
	always @(posedge clk_in) begin
		if (rst_in) begin
			lpf_act_r <= `LPF_RESET;
			shs_act_r <= `SHS_RESET;
			vertical_flip_out <= 1'b0;
			horizontal_flip_out <= 1'b0;
			frame_invalid_out <= 1'b0;
			frame_lines_out <= `LPF_RESET;
			measured_r <= 1'b0;
		end else if (fs_nxt) begin
			measured_r <= 1'b1;
			shs_act_r <= shs_r; // see R10 see R15
			if (master_r) begin
				lpf_act_r <= lpf_r; // see R15 see R5 see R7
				frame_lines_out <= lpf_r;
			end else if (measured_r) begin
				// The first sync edge ends no timed frame, so the reset length stays.
				lpf_act_r <= line_r + 18'h00001; // see R5 see R6
				frame_lines_out <= line_r + 18'h00001;
			end
			vertical_flip_out <= dir_r[`VFLIP_BIT]; // see R1
			horizontal_flip_out <= dir_r[`HFLIP_BIT]; // see R2
			frame_invalid_out <= (dir_r[`VFLIP_BIT] != vertical_flip_out) ||
				(dir_r[`HFLIP_BIT] != horizontal_flip_out); // see R3
		end
	end

	// Row reset by the shutter on the current line trails the readout by sweep plus one.
	always @* begin
		sweep_p1 = shs_act_r + 18'h00001;
		if (line_nxt >= sweep_p1) begin
			shut_nxt = line_nxt - sweep_p1; // see R11
		end else begin
			shut_nxt = line_nxt + lpf_act_r - sweep_p1;
		end
	end

	// Per-line outputs: strobes, row addresses, active window and integration length.
	always @(posedge clk_in) begin
		if (rst_in) begin
			frame_start_out <= 1'b0;
			line_start_out <= 1'b0;
			line_active_out <= 1'b0;
			read_row_out <= {`VALUE_W{1'b0}};
			shutter_row_out <= {`VALUE_W{1'b0}};
			integration_lines_out <= `LPF_RESET - `SHS_RESET - 18'h00001;
		end else begin
			frame_start_out <= fs_nxt;
			line_start_out <= ls_nxt;
			// Lines past the active window are rear blanking, however long the frame.
			line_active_out <= line_nxt < ACTIVE_LINES; // see R13
			if (vflip_nxt && line_nxt < ACTIVE_LINES) begin
				read_row_out <= act_last_w[`VALUE_W-1:0] - line_nxt; // see R1
			end else begin
				read_row_out <= line_nxt;
			end
			shutter_row_out <= shut_nxt;
			integration_lines_out <= lpf_act_r - sweep_p1; // see R4
		end
	end

endmodule
`default_nettype wire

//--- frame_ctrl_defines.vh
// Register addresses, field positions and reset values for the frame control block.
`ifndef FRAME_CTRL_DEFINES_VH
`define FRAME_CTRL_DEFINES_VH

// Byte addresses on the serial control port.
`define ADDR_READOUT_DIRECTION 16'h3007
`define ADDR_LPF_0 16'h3018
`define ADDR_LPF_1 16'h3019
`define ADDR_LPF_2 16'h301a
`define ADDR_SHS_0 16'h3020
`define ADDR_SHS_1 16'h3021
`define ADDR_SHS_2 16'h3022

// Field positions in the direction register.
`define VFLIP_BIT 0
`define HFLIP_BIT 1

// Register widths and reset values.
`define VALUE_W 18
`define LPF_RESET 18'h00465
`define SHS_RESET 18'h00000
`define DIR_RESET 2'h0

`endif

//--- frame_ctrl_properties.sv
// Port assertions for the frame control block.
`timescale 1ns/1ps
`default_nettype none
module frame_ctrl_checker #(
	parameter LINE_CYCLES = 16,
	parameter ACTIVE_LINES = 1097
) (
	// Clock, reset and strap.
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic master_mode_in,
	// Frame outputs.
	input wire logic frame_start_out,
	input wire logic line_start_out,
	input wire logic [17:0] read_row_out,
	input wire logic [17:0] integration_lines_out,
	input wire logic [17:0] frame_lines_out,
	input wire logic vertical_flip_out,
	input wire logic horizontal_flip_out,
	input wire logic frame_invalid_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// The gap holds only for the four-cycle line the bench builds.
	sequence s_line_gap;
		##1 !line_start_out [*3] ##1 line_start_out;
	endsequence
	a_frame_opens_line: assert property (frame_start_out |-> line_start_out)
		else $error("frame start without line start");
	a_master_line_gap: assert property (master_mode_in && line_start_out |-> s_line_gap)
		else $error("master line period wrong");
	a_first_row: assert property (frame_start_out |->
		read_row_out == (vertical_flip_out ? ACTIVE_LINES - 1 : 0))
		else $error("first row wrong");
	a_flip_hold: assert property (!frame_start_out |->
		$stable({vertical_flip_out, horizontal_flip_out, frame_invalid_out}))
		else $error("direction moved mid frame");
	a_invalid_flag: assert property (frame_start_out |-> frame_invalid_out ==
		({vertical_flip_out, horizontal_flip_out} !=
		$past({vertical_flip_out, horizontal_flip_out})))
		else $error("invalid flag wrong");
	a_integ_hold: assert property (!$past(frame_start_out) |->
		$stable(integration_lines_out))
		else $error("integration moved mid frame");
	a_lines_hold: assert property (!frame_start_out && !$past(frame_start_out) |->
		$stable(frame_lines_out))
		else $error("frame length moved mid frame");
	a_integ_below: assert property (!frame_start_out |->
		integration_lines_out < frame_lines_out)
		else $error("integration not below frame");
endmodule
bind exposure_and_readout_direction_ctrl frame_ctrl_checker #(.LINE_CYCLES(LINE_CYCLES),
	.ACTIVE_LINES(ACTIVE_LINES)) i_frame_ctrl_checker (.*);
`default_nettype wire

//--- sync_source.sv
// External sync generator model for slave mode.
`timescale 1ns/1ps
`default_nettype none
module sync_source #(
	parameter LINE_CYCLES = 6
) (
	// Control from the bench.
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic [7:0] lines_in,
	// Active low syncs, idle high as the pins are pulled up.
	output logic vertical_sync_pin_n_out = 1'b1,
	output logic horizontal_sync_pin_n_out = 1'b1
);
	int cyc = 0;
	int line = 0;
	// One low cycle per line; a longer frame is only more lines per vertical pulse.
	always @(posedge clk_in) begin
		vertical_sync_pin_n_out <= !(run_in && cyc == 0 && line == 0);
		horizontal_sync_pin_n_out <= !(run_in && cyc == 0);
		cyc <= (!run_in || cyc == LINE_CYCLES - 1) ? 0 : cyc + 1;
		if (!run_in)
			line <= 0;
		else if (cyc == LINE_CYCLES - 1)
			line <= (line + 1 >= lines_in) ? 0 : line + 1;
	end
endmodule
`default_nettype wire

//--- test_exposure_and_readout_direction_ctrl.sv
// Self-checking bench for the exposure and readout direction block.
`timescale 1ns/1ps
`default_nettype none
module test_exposure_and_readout_direction_ctrl;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic master_mode_in = 1'b1;
	logic run = 1'b0;
	logic [7:0] sync_lines = 8'h05;
	logic [15:0] reg_addr_in = 16'h0000;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	wire vertical_sync_pin_n_in, horizontal_sync_pin_n_in, frame_start_out, line_start_out;
	wire line_active_out, vertical_flip_out, horizontal_flip_out, frame_invalid_out;
	wire [7:0] reg_rdata_out;
	wire [17:0] read_row_out, shutter_row_out, integration_lines_out, frame_lines_out;
	int n_mismatch = 0;
	int n_compared = 0;
	int n;
	exposure_and_readout_direction_ctrl #(.LINE_CYCLES(4), .ACTIVE_LINES(8))
		i_exposure_and_readout_direction_ctrl (.*);
	sync_source #(.LINE_CYCLES(6)) i_sync_source (.clk_in(clk_in), .run_in(run),
		.lines_in(sync_lines), .vertical_sync_pin_n_out(vertical_sync_pin_n_in),
		.horizontal_sync_pin_n_out(horizontal_sync_pin_n_in));
	// Clock at 10 MHz.
	always #50 clk_in = ~clk_in;
	task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic step();
		@(posedge clk_in);
		#1;
	endtask
	// A quiet cycle after each strobe keeps every strobe a single pulse.
	task automatic wr(logic [15:0] a, logic [7:0] d);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		step();
		reg_wr_in = 1'b0;
		step();
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] exp, string what);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		step();
		reg_rd_in = 1'b0;
		step();
		check(what, {10'h000, reg_rdata_out}, {10'h000, exp});
	endtask
	// Returns cycles from the call to the next frame start, bounded against a hang.
	task automatic wait_fs(output int k);
		step();
		for (k = 1; k < 5000 && frame_start_out !== 1'b1; k++)
			step();
		if (frame_start_out !== 1'b1) begin
			check("frame start timeout", 18'h0, 18'h1);
			tally_and_finish();
		end
	endtask
	task automatic do_reset(logic m);
		rst_in = 1'b1;
		master_mode_in = m;
		run = 1'b0;
		repeat (6) step();
		rst_in = 1'b0;
	endtask
	task automatic t_regs();
		do_reset(1'b1);
		rd(16'h3007, 8'h00, "direction reset");
		rd(16'h3019, 8'h04, "lpf byte 1 reset");
		rd(16'h3022, 8'h00, "sweep byte 2 reset");
		rd(16'h3010, 8'h00, "unmapped read");
		wr(16'h3022, 8'hff);
		rd(16'h3022, 8'h03, "sweep byte 2 width");
		wr(16'h3007, 8'hff);
		rd(16'h3007, 8'h03, "direction bits");
		$display("t_regs done");
	endtask
	task automatic t_master();
		do_reset(1'b1);
		wr(16'h3018, 8'h0a);
		wr(16'h3019, 8'h00);
		wr(16'h3020, 8'h03);
		wait_fs(n);
		wait_fs(n);
		check("frame cycles", n[17:0], 18'd40);
		step();
		check("frame lines", frame_lines_out, 18'd10);
		check("integration", integration_lines_out, 18'd6);
		check("shutter row", shutter_row_out, 18'd6);
		check("line zero active", line_active_out, 18'h1);
		wr(16'h3020, 8'h05);
		wr(16'h3007, 8'h01);
		check("integration mid frame", integration_lines_out, 18'd6);
		wait_fs(n);
		check("vertical flip", {vertical_flip_out, frame_invalid_out}, 18'h3);
		check("first row", read_row_out, 18'd7);
		step();
		check("new integration", integration_lines_out, 18'd4);
		wr(16'h3007, 8'h02);
		wait_fs(n);
		check("horizontal flip", {vertical_flip_out, horizontal_flip_out}, 18'h1);
		wait_fs(n);
		check("valid again", frame_invalid_out, 18'h0);
		repeat (32) step();
		check("rear blanking line", line_active_out, 18'h0);
		check("blanking row", read_row_out, 18'd8);
		$display("t_master done");
	endtask
	task automatic t_slave();
		do_reset(1'b0);
		wr(16'h3020, 8'h01);
		run = 1'b1;
		repeat (3) wait_fs(n);
		check("slave frame gap", n[17:0], 18'd30);
		step();
		check("slave lines", frame_lines_out, 18'd5);
		check("slave integration", integration_lines_out, 18'd3);
		sync_lines = 8'h08;
		repeat (2) wait_fs(n);
		step();
		check("long frame lines", frame_lines_out, 18'd8);
		run = 1'b0;
		$display("t_slave done");
	endtask
	initial begin
		t_regs();
		t_master();
		t_slave();
		tally_and_finish();
	end
endmodule
`default_nettype wire
